/* design/mcr_mode_ctrl.sv */
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module mcr_mode_ctrl
    import mcr_pkg::*;
(
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // axi4-lite write
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // hardware events
    input  wire logic                  hw_safe_req,
    input  wire logic                  hw_exit_event,
    input  wire logic                  wakeup_pending,
    input  wire logic                  periph_irq_pending,
    // pad configuration
    input  wire logic [NUM_PAD-1:0]    pad_wake_line,
    input  wire logic [NUM_PAD-1:0]    pad_wake_pull_en,
    input  wire logic [NUM_PAD-1:0]    pad_unused,
    input  wire logic                  pb89_unpowered_in_standby,
    // mode and clock outputs
    output logic [3:0]                 cur_mode,
    output logic                       transition_in_progress,
    output logic [NUM_SRC-1:0]         clk_src_on,
    output logic [3:0]                 sysclk_sel,
    output logic [NUM_PERIPH-1:0]      periph_clk_en,
    output logic                       main_regulator_on,
    // pad outputs
    output logic [NUM_PAD-1:0]         pad_hiz,
    output logic [NUM_PAD-1:0]         pad_weak_pull_en,
    output logic [NUM_PAD-1:0]         pad_wake_en,
    output logic                       pad_output_power_down,
    output logic                       tdo_input_mode,
    output logic                       tdo_pull_up_en
);

    mcr_seq_if sq ();

    mcr_mode_seq u_seq (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sq      (sq.seq)
    );

    // ----------------
    // axi4-lite slave
    // ----------------
    logic              aw_hold_r, aw_hold_nxt;
    logic [7:0]        aw_addr_r, aw_addr_nxt;
    logic              w_hold_r, w_hold_nxt;
    logic [31:0]       w_data_r, w_data_nxt;
    logic [3:0]        w_strb_r, w_strb_nxt;
    logic              bvalid_r, bvalid_nxt;
    logic [1:0]        bresp_r, bresp_nxt;
    logic              rvalid_r, rvalid_nxt;
    logic [1:0]        rresp_r, rresp_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic              wr_go;
    logic [7:0]        wr_addr;
    logic [31:0]       wr_data;
    logic              wr_full;
    logic              wr_hit;
    logic              rd_hit;
    logic [31:0]       rd_val;

    // per-mode configuration memory; reserved codes hold nothing
    logic [CFG_W-1:0]  cfg_r [16];
    logic [CFG_W-1:0]  cfg_nxt [16];

    // mode request state
    logic [3:0]        cur_mode_r, cur_mode_nxt;
    logic [3:0]        tgt_mode_r, tgt_mode_nxt;
    logic [3:0]        pend_mode_r, pend_mode_nxt;
    logic [3:0]        ret_mode_r, ret_mode_nxt;
    logic              armed_r, armed_nxt;
    logic [3:0]        arm_mode_r, arm_mode_nxt;
    logic              start_r, start_nxt;
    logic              test_lock;
    logic              can_launch;

    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready  = !w_hold_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    assign wr_addr = aw_hold_r ? aw_addr_r : s_axi_awaddr;
    assign wr_data = w_hold_r ? w_data_r : s_axi_wdata;
    assign wr_full = (w_hold_r ? w_strb_r : s_axi_wstrb) == 4'hf;
    assign wr_go   = (aw_hold_r || (s_axi_awvalid && s_axi_awready))
                  && (w_hold_r || (s_axi_wvalid && s_axi_wready));
    assign wr_hit  = (wr_addr == OFS_MODE_CTRL) || (wr_addr == OFS_STATUS)
                  || ((wr_addr >= OFS_CFG_BASE) && (wr_addr <= OFS_CFG_LAST) && (wr_addr[1:0] == 2'b00));

    always_comb begin
        rd_hit = 1'b1;
        rd_val = '0;
        if (s_axi_araddr == OFS_MODE_CTRL) begin
            rd_val[MODE_LSB +: 4] = tgt_mode_r;
            rd_val[KEY_LSB +: 16] = KEY_INVERTED;
        end else if (s_axi_araddr == OFS_STATUS) begin
            rd_val[ST_BUSY_BIT]          = transition_in_progress;
            rd_val[ST_LOCK_BIT]          = test_lock;
            rd_val[ST_MODE_LSB +: 4]     = cur_mode_r;
            rd_val[ST_SYS_LSB +: 4]      = sq.sysclk_sel;
            rd_val[ST_SRC_LSB +: NUM_SRC] = sq.src_on;
        end else if ((s_axi_araddr >= OFS_CFG_BASE) && (s_axi_araddr <= OFS_CFG_LAST)
                     && (s_axi_araddr[1:0] == 2'b00)) begin
            rd_val[CFG_W-1:0] = cfg_r[s_axi_araddr[5:2]];
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_comb begin
        aw_hold_nxt = aw_hold_r;
        aw_addr_nxt = aw_addr_r;
        w_hold_nxt  = w_hold_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r && !s_axi_bready;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r && !s_axi_rready;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (wr_go) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_nxt  = rd_val;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_hold_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            rvalid_r  <= 1'b0;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_hold_r  <= w_hold_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // ----------------
    // keyed mode requests and hardware overrides
    // ----------------
    // test mode with the system clock stopped cannot run the sequencer
    assign test_lock  = (cur_mode_r == MODE_TEST) && (sq.sysclk_sel == SYSCLK_OFF);
    // done cycle still shows the old mode, so a launch there would repeat
    assign can_launch = !start_r && !sq.busy && !sq.done && !test_lock;

    always_comb begin
        logic [3:0] wm;
        logic [15:0] wk;
        logic       lp_ok;
        wm = wr_data[MODE_LSB +: 4];
        wk = wr_data[KEY_LSB +: 16];
        lp_ok = 1'b1;
        cur_mode_nxt  = sq.done ? pend_mode_r : cur_mode_r;
        tgt_mode_nxt  = tgt_mode_r;
        pend_mode_nxt = pend_mode_r;
        ret_mode_nxt  = ret_mode_r;
        armed_nxt     = armed_r;
        arm_mode_nxt  = arm_mode_r;
        start_nxt     = 1'b0;
        for (int m = 0; m < 16; m++) begin
            cfg_nxt[m] = cfg_r[m];
        end
        if (wr_go && wr_full && (wr_addr >= OFS_CFG_BASE) && (wr_addr <= OFS_CFG_LAST)
            && !mode_reserved(wr_addr[5:2])) begin
            cfg_nxt[wr_addr[5:2]] = wr_data[CFG_W-1:0];
        end
        if (wr_go && wr_full && (wr_addr == OFS_MODE_CTRL)) begin
            if (wk == KEY_VALUE) begin
                armed_nxt    = !mode_reserved(wm);
                arm_mode_nxt = wm;
            end else if (wk == KEY_INVERTED) begin
                armed_nxt = 1'b0;
                if ((wm == MODE_HALT) || (wm == MODE_STOP)) begin
                    lp_ok = mode_is_run(cur_mode_r);
                end else if (wm == MODE_STANDBY) begin
                    lp_ok = mode_is_run(cur_mode_r) || (cur_mode_r == MODE_DEFAULT_RUN_STATE);
                end
                if ((wm == MODE_HALT) || (wm == MODE_STOP) || (wm == MODE_STANDBY)) begin
                    lp_ok = lp_ok && !wakeup_pending && !periph_irq_pending;
                end
                if (armed_r && (arm_mode_r == wm) && lp_ok && can_launch) begin
                    tgt_mode_nxt  = wm;
                    pend_mode_nxt = wm;
                    start_nxt     = 1'b1;
                    if (mode_is_run(cur_mode_r)) begin
                        ret_mode_nxt = cur_mode_r;
                    end
                end
            end
            // any other key: no state touched
        end else if (wr_go) begin
            armed_nxt = 1'b0;
        end
        // hardware events take priority over a software pair in the same cycle
        if (hw_exit_event && can_launch
            && ((cur_mode_r == MODE_HALT) || (cur_mode_r == MODE_STOP))) begin
            tgt_mode_nxt  = ret_mode_r;
            pend_mode_nxt = ret_mode_r;
            start_nxt     = 1'b1;
        end
        if (hw_safe_req && can_launch && (cur_mode_r != MODE_SAFE)) begin
            tgt_mode_nxt  = MODE_SAFE;
            pend_mode_nxt = MODE_SAFE;
            start_nxt     = 1'b1;
            armed_nxt     = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_mode_r  <= MODE_DEFAULT_RUN_STATE;
            tgt_mode_r  <= MODE_DEFAULT_RUN_STATE;
            pend_mode_r <= MODE_DEFAULT_RUN_STATE;
            ret_mode_r  <= MODE_RUN_STATE_ZERO;
            armed_r     <= 1'b0;
            arm_mode_r  <= MODE_RESET;
            start_r     <= 1'b0;
            for (int m = 0; m < 16; m++) begin
                cfg_r[m] <= mode_reserved(4'(m)) ? '0 : CFG_RESET;
            end
        end else begin
            cur_mode_r  <= cur_mode_nxt;
            tgt_mode_r  <= tgt_mode_nxt;
            pend_mode_r <= pend_mode_nxt;
            ret_mode_r  <= ret_mode_nxt;
            armed_r     <= armed_nxt;
            arm_mode_r  <= arm_mode_nxt;
            start_r     <= start_nxt;
            for (int m = 0; m < 16; m++) begin
                cfg_r[m] <= cfg_nxt[m];
            end
        end
    end

    assign sq.start = start_r;
    assign sq.cfg   = cfg_r[pend_mode_r];

    assign cur_mode               = cur_mode_r;
    assign transition_in_progress = start_r || sq.busy || sq.done;
    assign clk_src_on             = sq.src_on;
    assign sysclk_sel             = sq.sysclk_sel;
    assign periph_clk_en          = sq.periph_en;

    // ----------------
    // pad control in standby; output power-down also in safe
    // ----------------
    logic                  sby;
    logic [NUM_PAD-1:0]    hiz_r, hiz_nxt;
    logic [NUM_PAD-1:0]    pull_r, pull_nxt;
    logic [NUM_PAD-1:0]    wake_r, wake_nxt;
    logic                  pdo_r, pdo_nxt;
    logic                  reg_r, reg_nxt;

    assign sby = (cur_mode_r == MODE_STANDBY);

    generate
        for (genvar p = 0; p < NUM_PAD; p++) begin : g_pad
            always_comb begin
                // these two pads lose supply when the main regulator stops
                wake_nxt[p] = pad_wake_line[p] && !(pb89_unpowered_in_standby
                              && ((p == PAD_PB8) || (p == PAD_PB9)));
                hiz_nxt[p]  = sby && !(wake_nxt[p] && pad_wake_pull_en[p]);
                pull_nxt[p] = sby && pad_unused[p];
            end
        end
    endgenerate

    always_comb begin
        pdo_nxt = sby || (cur_mode_r == MODE_SAFE);
        reg_nxt = !sby;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hiz_r  <= '0;
            pull_r <= '0;
            wake_r <= '0;
            pdo_r  <= 1'b0;
            reg_r  <= 1'b1;
        end else begin
            hiz_r  <= hiz_nxt;
            pull_r <= pull_nxt;
            wake_r <= wake_nxt;
            pdo_r  <= pdo_nxt;
            reg_r  <= reg_nxt;
        end
    end

    assign pad_hiz               = hiz_r;
    assign pad_weak_pull_en      = pull_r;
    assign pad_wake_en           = wake_r;
    assign pad_output_power_down = pdo_r;
    assign main_regulator_on     = reg_r;
    assign tdo_input_mode        = !reg_r;
    assign tdo_pull_up_en        = 1'b0;

endmodule

/* design/mcr_pkg.sv */
package mcr_pkg;

    // ----------------
    // mode codes
    // ----------------
    localparam logic [3:0] MODE_RESET    = 4'h0;
    localparam logic [3:0] MODE_TEST     = 4'h1;
    localparam logic [3:0] MODE_SAFE     = 4'h2;
    localparam logic [3:0] MODE_DEFAULT_RUN_STATE     = 4'h3;
    localparam logic [3:0] MODE_RUN_STATE_ZERO     = 4'h4;
    localparam logic [3:0] MODE_RUN_STATE_THREE     = 4'h7;
    localparam logic [3:0] MODE_HALT     = 4'h8;
    localparam logic [3:0] MODE_STOP     = 4'ha;
    localparam logic [3:0] MODE_STANDBY  = 4'hd;

    // ----------------
    // mode control register layout
    // ----------------
    localparam logic [15:0] KEY_VALUE     = 16'h5af0;
    localparam logic [15:0] KEY_INVERTED  = 16'ha50f;
    localparam int          MODE_LSB      = 28;
    localparam int          KEY_LSB       = 0;

    // ----------------
    // register offsets
    // ----------------
    localparam logic [7:0] OFS_MODE_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_CFG_BASE  = 8'h40;
    localparam logic [7:0] OFS_CFG_LAST  = 8'h7c;

    // ----------------
    // per-mode configuration fields
    // ----------------
    localparam int          NUM_SRC      = 3;
    localparam int          NUM_PERIPH   = 8;
    localparam int          NUM_PAD      = 16;
    localparam int          CFG_W        = 20;
    localparam int          CFG_SRC_LSB  = 0;
    localparam int          CFG_SYS_LSB  = 4;
    localparam int          CFG_GATE_LSB = 8;
    localparam int          CFG_DIV_LSB  = 16;
    localparam logic [CFG_W-1:0] CFG_RESET = 20'h0ff01;
    localparam logic [3:0]  SYSCLK_OFF   = 4'hf;

    // ----------------
    // status register fields
    // ----------------
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_LOCK_BIT  = 1;
    localparam int ST_MODE_LSB  = 4;
    localparam int ST_SYS_LSB   = 8;
    localparam int ST_SRC_LSB   = 12;

    // ----------------
    // pads
    // ----------------
    localparam int PAD_PB8 = 8;
    localparam int PAD_PB9 = 9;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    function automatic logic mode_reserved(input logic [3:0] m);
        return (m == 4'h9) || (m == 4'hb) || (m == 4'hc) || (m == 4'he) || (m == 4'hf);
    endfunction

    function automatic logic mode_is_run(input logic [3:0] m);
        return (m >= MODE_RUN_STATE_ZERO) && (m <= MODE_RUN_STATE_THREE);
    endfunction

    typedef enum logic [3:0] {
        SEQ_IDLE = 4'b0001,
        SEQ_SRC  = 4'b0010,
        SEQ_SEL  = 4'b0100,
        SEQ_PERI = 4'b1000
    } mcr_seq_e;

endpackage

/* design/mcr_seq_if.sv */
`timescale 1ns/1ps
interface mcr_seq_if;
    import mcr_pkg::*;
    logic                  start;
    logic [CFG_W-1:0]      cfg;
    logic                  busy;
    logic                  done;
    logic [NUM_SRC-1:0]    src_on;
    logic [3:0]            sysclk_sel;
    logic [NUM_PERIPH-1:0] periph_en;

    modport ctrl (output start, output cfg, input busy, input done,
                  input src_on, input sysclk_sel, input periph_en);
    modport seq  (input start, input cfg, output busy, output done,
                  output src_on, output sysclk_sel, output periph_en);
endinterface

/* design/mcr_mode_seq.sv */
`timescale 1ns/1ps
module mcr_mode_seq
    import mcr_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control side
    mcr_seq_if.seq   sq
);

    mcr_seq_e              st_r, st_nxt;
    logic [CFG_W-1:0]      cfg_r, cfg_nxt;
    logic [NUM_SRC-1:0]    src_r, src_nxt;
    logic [3:0]            sys_r, sys_nxt;
    logic [NUM_PERIPH-1:0] gate_r, gate_nxt;
    logic [3:0]            div_r, div_nxt;
    logic [3:0]            cnt_r, cnt_nxt;
    logic                  done_r, done_nxt;
    logic [NUM_PERIPH-1:0] pen_r, pen_nxt;
    logic                  tick;

    // ----------------
    // transition steps
    // ----------------
    always_comb begin
        st_nxt   = st_r;
        cfg_nxt  = cfg_r;
        src_nxt  = src_r;
        sys_nxt  = sys_r;
        gate_nxt = gate_r;
        div_nxt  = div_r;
        done_nxt = 1'b0;
        case (st_r)
            SEQ_IDLE: begin
                if (sq.start) begin
                    cfg_nxt = sq.cfg;
                    st_nxt  = SEQ_SRC;
                end
            end
            SEQ_SRC: begin
                src_nxt = cfg_r[CFG_SRC_LSB +: NUM_SRC];
                st_nxt  = SEQ_SEL;
            end
            SEQ_SEL: begin
                // source must be on before it is selected
                sys_nxt = cfg_r[CFG_SYS_LSB +: 4];
                st_nxt  = SEQ_PERI;
            end
            SEQ_PERI: begin
                gate_nxt = cfg_r[CFG_GATE_LSB +: NUM_PERIPH];
                div_nxt  = cfg_r[CFG_DIV_LSB +: 4];
                done_nxt = 1'b1;
                st_nxt   = SEQ_IDLE;
            end
            default: st_nxt = SEQ_IDLE;
        endcase
    end

    // ----------------
    // peripheral clock divider, divide by ratio + 1
    // ----------------
    assign tick = (cnt_r >= div_r);

    always_comb begin
        cnt_nxt = tick ? 4'h0 : cnt_r + 4'h1;
    end

    generate
        for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_pen
            always_comb begin
                pen_nxt[i] = gate_r[i] & tick;
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r   <= SEQ_IDLE;
            cfg_r  <= CFG_RESET;
            src_r  <= CFG_RESET[CFG_SRC_LSB +: NUM_SRC];
            sys_r  <= CFG_RESET[CFG_SYS_LSB +: 4];
            gate_r <= CFG_RESET[CFG_GATE_LSB +: NUM_PERIPH];
            div_r  <= CFG_RESET[CFG_DIV_LSB +: 4];
            cnt_r  <= 4'h0;
            done_r <= 1'b0;
            pen_r  <= '0;
        end else begin
            st_r   <= st_nxt;
            cfg_r  <= cfg_nxt;
            src_r  <= src_nxt;
            sys_r  <= sys_nxt;
            gate_r <= gate_nxt;
            div_r  <= div_nxt;
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
            pen_r  <= pen_nxt;
        end
    end

    assign sq.busy       = (st_r != SEQ_IDLE);
    assign sq.done       = done_r;
    assign sq.src_on     = src_r;
    assign sq.sysclk_sel = sys_r;
    assign sq.periph_en  = pen_r;

endmodule

/* dv/mcr_mon_monitor.sv */
`timescale 1ns/1ps
module mcr_mon
    import mcr_pkg::*;
(
    // clock and mode
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic [3:0]         cur_mode,
    input wire logic               transition_in_progress,
    input wire logic [NUM_SRC-1:0] clk_src_on,
    input wire logic [3:0]         sysclk_sel,
    // pads
    input wire logic [NUM_PAD-1:0] pad_hiz,
    input wire logic [NUM_PAD-1:0] pad_weak_pull_en,
    input wire logic [NUM_PAD-1:0] pad_wake_en,
    input wire logic [NUM_PAD-1:0] pad_wake_line,
    input wire logic [NUM_PAD-1:0] pad_wake_pull_en,
    input wire logic [NUM_PAD-1:0] pad_unused,
    input wire logic               pb89_unpowered_in_standby,
    input wire logic               tdo_input_mode,
    input wire logic               tdo_pull_up_en
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic               sb_r;
    logic [NUM_PAD-1:0] wk;
    // pad outputs lag the mode by a cycle
    always_ff @(posedge aclk) sb_r <= aresetn && (cur_mode == MODE_STANDBY);
    assign wk = pad_wake_line & pad_wake_pull_en & ~({NUM_PAD{pb89_unpowered_in_standby}} & 16'h0300);
    property p_busy; $rose(transition_in_progress) |-> ##[1:8] !transition_in_progress; endproperty
    property p_src; $changed(clk_src_on) |-> transition_in_progress; endproperty
    property p_sel; $changed(sysclk_sel) |-> transition_in_progress && $stable(clk_src_on); endproperty
    property p_rsv; !mode_reserved(cur_mode); endproperty
    property p_lock; cur_mode == MODE_TEST && sysclk_sel == SYSCLK_OFF |=> cur_mode == MODE_TEST; endproperty
    property p_hiz; sb_r |-> pad_hiz == ~wk; endproperty
    property p_pull; sb_r |-> (pad_unused & ~pad_weak_pull_en) == '0; endproperty
    property p_tdo; sb_r |-> tdo_input_mode && !tdo_pull_up_en; endproperty
    property p_pb; sb_r && pb89_unpowered_in_standby |-> pad_wake_en[9:8] == 2'b00; endproperty
    a_busy: assert property (p_busy) else $error("flag stuck");
    a_src: assert property (p_src) else $error("sources moved idle");
    a_sel: assert property (p_sel) else $error("select order");
    a_rsv: assert property (p_rsv) else $error("reserved mode");
    a_lock: assert property (p_lock) else $error("test left");
    a_hiz: assert property (p_hiz) else $error("standby hiz");
    a_pull: assert property (p_pull) else $error("unused pull");
    a_tdo: assert property (p_tdo) else $error("debug pad");
    a_pb: assert property (p_pb) else $error("pb wake");
    c_tr: cover property ($rose(transition_in_progress));
    c_sb: cover property (sb_r);
    c_sf: cover property (cur_mode == MODE_SAFE);
endmodule

/* dv/mode_change_request_ctrl_tb.sv */
`timescale 1ns/1ps
module mode_change_request_ctrl_tb;
    import mcr_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, hw_safe_req = 0, hw_exit_event = 0;
    logic wakeup_pending = 0, periph_irq_pending = 0, pb89_unpowered_in_standby = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, st = 95849, d;
    logic [3:0] s_axi_wstrb = 4'hf, cm, m;
    logic [NUM_PAD-1:0] pad_wake_line = 0, pad_wake_pull_en = 0, pad_unused = 0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic transition_in_progress, main_regulator_on, pad_output_power_down, tdo_input_mode, tdo_pull_up_en;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [3:0] cur_mode, sysclk_sel;
    wire logic [NUM_SRC-1:0] clk_src_on;
    wire logic [NUM_PERIPH-1:0] periph_clk_en;
    wire logic [NUM_PAD-1:0] pad_hiz, pad_weak_pull_en, pad_wake_en;
    logic [1:0] r;
    logic [3:0] mt [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h3, 4'h9, 4'he, 4'hc};
    int n_mismatch = 0, checked = 0;
    mcr_mode_ctrl u_dut (.*);
    always #20 aclk = ~aclk;
    // ----------------
    // helpers
    // ----------------
    function automatic logic [31:0] rnd();
        st ^= st << 13;
        st ^= st >> 17;
        st ^= st << 5;
        return st;
    endfunction
    function automatic logic [3:0] em(input logic [3:0] c, input logic [3:0] t);
        return (t inside {4'h9, 4'hb, 4'hc, 4'he, 4'hf}) ? c : t;
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic lim(input int i);
        if (i >= 60) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        int i;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= w;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (i = 0; i < 60; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 0;
        lim(i);
    endtask
    task automatic rd(input logic [7:0] a);
        int i;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (i = 0; i < 60; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        s_axi_rready <= 0;
        lim(i);
    endtask
    task automatic pair(input logic [3:0] a, input logic [3:0] b, input logic [15:0] k);
        wr(OFS_MODE_CTRL, {a, 12'h0, k});
        wr(OFS_MODE_CTRL, {b, 12'h0, KEY_INVERTED});
    endtask
    task automatic waitm(input logic [3:0] t);
        int i;
        for (i = 0; i < 60 && !(cur_mode === t && !transition_in_progress); i++) @(posedge aclk);
        lim(i);
        cm = t;
        chk(cur_mode, t);
    endtask
    // ----------------
    // main sequence
    // ----------------
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        cm = MODE_DEFAULT_RUN_STATE;
        rd(OFS_MODE_CTRL);
        chk(d, {MODE_DEFAULT_RUN_STATE, 12'h0, KEY_INVERTED});
        for (int k = 0; k < 12; k++) begin
            m = mt[rnd() & 32'h7];
            pair(m, m, KEY_VALUE);
            waitm(em(cm, m));
            rd(OFS_MODE_CTRL);
            chk(d, {cm, 12'h0, KEY_INVERTED});
        end
        pair(4'h6, 4'h6, 16'(rnd()));
        chk(transition_in_progress, 0);
        pair(4'h5, 4'h6, KEY_VALUE);
        chk(transition_in_progress, 0);
        wr(OFS_MODE_CTRL, {4'h5, 12'h0, KEY_VALUE});
        wr(OFS_STATUS, 0);
        wr(OFS_MODE_CTRL, {4'h5, 12'h0, KEY_INVERTED});
        chk(transition_in_progress, 0);
        wr(8'h20, 0);
        chk(r, RESP_SLVERR);
        pair(4'h5, 4'h5, KEY_VALUE);
        waitm(4'h5);
        wakeup_pending <= 1;
        pair(MODE_HALT, MODE_HALT, KEY_VALUE);
        chk(transition_in_progress, 0);
        {wakeup_pending, periph_irq_pending} <= 2'b01;
        pair(MODE_STOP, MODE_STOP, KEY_VALUE);
        chk(transition_in_progress, 0);
        periph_irq_pending <= 0;
        pair(MODE_HALT, MODE_HALT, KEY_VALUE);
        waitm(MODE_HALT);
        hw_exit_event <= 1;
        @(posedge aclk);
        hw_exit_event <= 0;
        waitm(4'h5);
        hw_safe_req <= 1;
        waitm(MODE_SAFE);
        hw_safe_req <= 0;
        rd(OFS_MODE_CTRL);
        chk(d[31:28], MODE_SAFE);
        pair(MODE_DEFAULT_RUN_STATE, MODE_DEFAULT_RUN_STATE, KEY_VALUE);
        waitm(MODE_DEFAULT_RUN_STATE);
        wr(8'h44, 32'h0fff1);
        pair(MODE_TEST, MODE_TEST, KEY_VALUE);
        waitm(MODE_TEST);
        pair(MODE_DEFAULT_RUN_STATE, MODE_DEFAULT_RUN_STATE, KEY_VALUE);
        repeat (8) @(posedge aclk);
        chk(cur_mode, MODE_TEST);
        aresetn <= 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        pad_wake_line <= 16'(rnd());
        pad_wake_pull_en <= 16'(rnd());
        pad_unused <= 16'(rnd());
        pb89_unpowered_in_standby <= 1;
        pair(MODE_STANDBY, MODE_STANDBY, KEY_VALUE);
        waitm(MODE_STANDBY);
        repeat (4) @(posedge aclk);
        chk({main_regulator_on, pad_output_power_down, tdo_input_mode, tdo_pull_up_en,
             periph_clk_en, clk_src_on, sysclk_sel}, {4'b0110, 8'hff, 3'b001, 4'h0});
        chk(pad_hiz ^ pad_wake_line & pad_wake_pull_en & ~16'h0300, 16'hffff);
        chk(pad_weak_pull_en, pad_unused);
        chk(pad_wake_en, pad_wake_line & ~16'h0300);
        tally_and_finish();
    end
endmodule
bind mcr_mode_ctrl mcr_mon u_mon (.*);
